// >>> spr_consts.svh
// offsets, field positions, codes and reset values of the pin router
// assumes inclusion by bare name from package and design files
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPR_IDX_SERIAL_A 4'h2
`define SPR_IDX_SERIAL_B 4'h3
`define SPR_IDX_SPI 4'h4
`define SPR_IDX_TWO_WIRE 4'h5
`define SPR_ADDR_W 8

// ----------------------------------------------------------------
// reset values and writable bit masks
// ----------------------------------------------------------------
`define SPR_ROUTE_RST 8'h00
`define SPR_MASK_SERIAL_A 8'hFF
`define SPR_MASK_LOW_NIBBLE 8'h0F

// ----------------------------------------------------------------
// route field positions (low bit of each two-bit field)
// ----------------------------------------------------------------
`define SPR_F_SERIAL0 0
`define SPR_F_SERIAL1 2
`define SPR_F_SERIAL2 4
`define SPR_F_SERIAL3 6
`define SPR_F_SERIAL4 0
`define SPR_F_SERIAL5 2
`define SPR_F_UNIT0 0
`define SPR_F_UNIT1 2

// ----------------------------------------------------------------
// route codes
// ----------------------------------------------------------------
`define SPR_CODE_DEFAULT 2'h0
`define SPR_CODE_FIRST_ALTERNATE_POSITION 2'h1
`define SPR_CODE_SECOND_ALTERNATE_POSITION 2'h2
`define SPR_CODE_NONE 2'h3

// ----------------------------------------------------------------
// pad ports, pin groups and signal masks
// ----------------------------------------------------------------
`define SPR_PORT_A 3'h0
`define SPR_PORT_B 3'h1
`define SPR_PORT_C 3'h2
`define SPR_PORT_E 3'h3
`define SPR_PORT_F 3'h4
`define SPR_PORT_G 3'h5
`define SPR_PORTS 6
`define SPR_GROUPS 12
`define SPR_G_SPI0 6
`define SPR_G_SPI1 7
`define SPR_G_TW0_HOST 8
`define SPR_G_TW0_CLIENT 9
`define SPR_G_TW1_HOST 10
`define SPR_G_TW1_CLIENT 11
`define SPR_SIG_ALL 4'hF
`define SPR_SIG_PAIR 4'h3

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define SPR_RESP_OKAY 2'h0
`define SPR_RESP_SLVERR 2'h2

`endif

// >>> spr_pkg.sv
// types shared by the pin router and its surroundings
// assumes spr_consts.svh is on the include path
`include "spr_consts.svh"

package spr_pkg;

    // four signals of one peripheral pin group
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } spr_sig_drive_t;

    // one eight-pin pad port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } spr_pad_drive_t;

    // where a pin group lands
    typedef struct packed {
        logic en;
        logic [2:0] port;
        logic [2:0] base;
        logic [3:0] mask;
    } spr_place_t;

    typedef struct packed {
        logic awvalid;
        logic [`SPR_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`SPR_ADDR_W-1:0] araddr;
        logic rready;
    } spr_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } spr_axil_rsp_t;

endpackage : spr_pkg

// >>> spr_sync2.sv
// two-flop synchroniser for pad levels
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/10ps

module spr_sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1_ff <= '0;
            sync_out <= '0;
        end else begin
            stage1_ff <= async_in;
            sync_out <= stage1_ff;
        end
    end

endmodule : spr_sync2

// >>> spr_pin_router.sv
// pin router: steers serial, spi and two-wire pin groups onto pad ports
// assumes an AXI4-Lite master on ref_clk and pads on asynchronous pins
`timescale 1ns/10ps
`include "spr_consts.svh"

module spr_pin_router (
    input wire logic ref_clk,
    input wire logic reset,
    input wire spr_pkg::spr_axil_req_t axil_req,
    output spr_pkg::spr_axil_rsp_t axil_rsp,
    input wire spr_pkg::spr_sig_drive_t [`SPR_GROUPS-1:0] unit_drive,
    output logic [`SPR_GROUPS-1:0][3:0] unit_in,
    input wire logic [`SPR_PORTS-1:0][7:0] pad_in,
    output spr_pkg::spr_pad_drive_t [`SPR_PORTS-1:0] pad_drive
);

    // ----------------------------------------------------------------
    // route registers and bus state
    // ----------------------------------------------------------------
    logic [7:0] serial_pin_route_a_ff;
    logic [7:0] serial_pin_route_b_ff;
    logic [7:0] spi_pin_route_ff;
    logic [7:0] two_wire_pin_route_ff;
    logic aw_held_ff;
    logic [`SPR_ADDR_W-1:0] aw_addr_ff;
    logic w_held_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic wr_do;
    logic wr_lane0;
    logic [3:0] wr_idx;
    logic wr_mapped;
    spr_pkg::spr_place_t [`SPR_GROUPS-1:0] place;
    logic [`SPR_PORTS-1:0][7:0] pad_sync;
    spr_pkg::spr_pad_drive_t [`SPR_PORTS-1:0] nxt_pad_drive;
    logic [`SPR_GROUPS-1:0][3:0] nxt_unit_in;

    function automatic logic is_mapped(input logic [`SPR_ADDR_W-1:0] addr);
        logic [3:0] idx;
        idx = addr[5:2];
        if (addr[7:6] != 2'h0 || addr[1:0] != 2'h0) begin
            return 1'b0;
        end else if (idx == `SPR_IDX_SERIAL_A || idx == `SPR_IDX_SERIAL_B) begin
            return 1'b1;
        end else if (idx == `SPR_IDX_SPI || idx == `SPR_IDX_TWO_WIRE) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : is_mapped

    function automatic spr_pkg::spr_place_t at(input logic [2:0] port,
                                               input logic [2:0] base,
                                               input logic [3:0] mask);
        spr_pkg::spr_place_t p;
        p.en = 1'b1;
        p.port = port;
        p.base = base;
        p.mask = mask;
        return p;
    endfunction : at

    // four-signal serial group: default low nibble, first_alternate_position high nibble masked by alt_mask
    function automatic spr_pkg::spr_place_t serial_at(input logic [1:0] code,
                                                      input logic [2:0] port,
                                                      input logic [3:0] alt_mask);
        spr_pkg::spr_place_t p;
        p = '0;
        case (code)
            `SPR_CODE_DEFAULT: p = at(port, 3'h0, `SPR_SIG_ALL);
            `SPR_CODE_FIRST_ALTERNATE_POSITION: p = at(port, 3'h4, alt_mask);
            default: p = '0;
        endcase
        return p;
    endfunction : serial_at

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign axil_rsp.awready = !aw_held_ff;
    assign axil_rsp.wready = !w_held_ff;
    assign axil_rsp.arready = !rvalid_ff;
    assign axil_rsp.bvalid = bvalid_ff;
    assign axil_rsp.bresp = bresp_ff;
    assign axil_rsp.rvalid = rvalid_ff;
    assign axil_rsp.rdata = rdata_ff;
    assign axil_rsp.rresp = rresp_ff;

    assign wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx = aw_addr_ff[5:2];
    assign wr_mapped = is_mapped(aw_addr_ff);
    assign wr_lane0 = wr_do && wr_mapped && w_strb_ff[0];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (axil_req.awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= axil_req.awaddr;
        end else if (wr_do) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            w_held_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (axil_req.wvalid && !w_held_ff) begin
            w_held_ff <= 1'b1;
            w_data_ff <= axil_req.wdata;
            w_strb_ff <= axil_req.wstrb;
        end else if (wr_do) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `SPR_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
        end else if (axil_req.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // reserved bits are not stored and read back as zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            serial_pin_route_a_ff <= `SPR_ROUTE_RST;
            serial_pin_route_b_ff <= `SPR_ROUTE_RST;
            spi_pin_route_ff <= `SPR_ROUTE_RST;
            two_wire_pin_route_ff <= `SPR_ROUTE_RST;
        end else if (wr_lane0) begin
            if (wr_idx == `SPR_IDX_SERIAL_A) begin
                serial_pin_route_a_ff <= w_data_ff[7:0] & `SPR_MASK_SERIAL_A;
            end else if (wr_idx == `SPR_IDX_SERIAL_B) begin
                serial_pin_route_b_ff <= w_data_ff[7:0] & `SPR_MASK_LOW_NIBBLE;
            end else if (wr_idx == `SPR_IDX_SPI) begin
                spi_pin_route_ff <= w_data_ff[7:0] & `SPR_MASK_LOW_NIBBLE;
            end else if (wr_idx == `SPR_IDX_TWO_WIRE) begin
                two_wire_pin_route_ff <= w_data_ff[7:0] & `SPR_MASK_LOW_NIBBLE;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `SPR_RESP_OKAY;
        end else if (axil_req.arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= is_mapped(axil_req.araddr) ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
            if (!is_mapped(axil_req.araddr)) begin
                rdata_ff <= '0;
            end else if (axil_req.araddr[5:2] == `SPR_IDX_SERIAL_A) begin
                rdata_ff <= {24'h000000, serial_pin_route_a_ff};
            end else if (axil_req.araddr[5:2] == `SPR_IDX_SERIAL_B) begin
                rdata_ff <= {24'h000000, serial_pin_route_b_ff};
            end else if (axil_req.araddr[5:2] == `SPR_IDX_SPI) begin
                rdata_ff <= {24'h000000, spi_pin_route_ff};
            end else begin
                rdata_ff <= {24'h000000, two_wire_pin_route_ff};
            end
        end else if (axil_req.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // route decode
    // ----------------------------------------------------------------
    always_comb begin
        place[0] = serial_at(serial_pin_route_a_ff[`SPR_F_SERIAL0 +: 2],
                             `SPR_PORT_A, `SPR_SIG_ALL);
        place[1] = serial_at(serial_pin_route_a_ff[`SPR_F_SERIAL1 +: 2],
                             `SPR_PORT_C, `SPR_SIG_ALL);
        place[2] = serial_at(serial_pin_route_a_ff[`SPR_F_SERIAL2 +: 2],
                             `SPR_PORT_F, `SPR_SIG_PAIR);
        place[3] = serial_at(serial_pin_route_a_ff[`SPR_F_SERIAL3 +: 2],
                             `SPR_PORT_B, `SPR_SIG_ALL);
        place[4] = serial_at(serial_pin_route_b_ff[`SPR_F_SERIAL4 +: 2],
                             `SPR_PORT_E, `SPR_SIG_ALL);
        place[5] = serial_at(serial_pin_route_b_ff[`SPR_F_SERIAL5 +: 2],
                             `SPR_PORT_G, `SPR_SIG_ALL);
        case (spi_pin_route_ff[`SPR_F_UNIT0 +: 2])
            `SPR_CODE_DEFAULT: place[`SPR_G_SPI0] = at(`SPR_PORT_A, 3'h4, `SPR_SIG_ALL);
            `SPR_CODE_FIRST_ALTERNATE_POSITION: place[`SPR_G_SPI0] = at(`SPR_PORT_E, 3'h0, `SPR_SIG_ALL);
            `SPR_CODE_SECOND_ALTERNATE_POSITION: place[`SPR_G_SPI0] = at(`SPR_PORT_G, 3'h4, `SPR_SIG_ALL);
            default: place[`SPR_G_SPI0] = '0;
        endcase
        case (spi_pin_route_ff[`SPR_F_UNIT1 +: 2])
            `SPR_CODE_DEFAULT: place[`SPR_G_SPI1] = at(`SPR_PORT_C, 3'h0, `SPR_SIG_ALL);
            `SPR_CODE_FIRST_ALTERNATE_POSITION: place[`SPR_G_SPI1] = at(`SPR_PORT_C, 3'h4, `SPR_SIG_ALL);
            `SPR_CODE_SECOND_ALTERNATE_POSITION: place[`SPR_G_SPI1] = at(`SPR_PORT_B, 3'h4, `SPR_SIG_ALL);
            default: place[`SPR_G_SPI1] = '0;
        endcase
        place[`SPR_G_TW0_HOST] = '0;
        place[`SPR_G_TW0_CLIENT] = '0;
        case (two_wire_pin_route_ff[`SPR_F_UNIT0 +: 2])
            `SPR_CODE_DEFAULT: begin
                place[`SPR_G_TW0_HOST] = at(`SPR_PORT_A, 3'h2, `SPR_SIG_PAIR);
                place[`SPR_G_TW0_CLIENT] = at(`SPR_PORT_C, 3'h2, `SPR_SIG_PAIR);
            end
            `SPR_CODE_FIRST_ALTERNATE_POSITION: begin
                place[`SPR_G_TW0_HOST] = at(`SPR_PORT_A, 3'h2, `SPR_SIG_PAIR);
                place[`SPR_G_TW0_CLIENT] = at(`SPR_PORT_C, 3'h6, `SPR_SIG_PAIR);
            end
            `SPR_CODE_SECOND_ALTERNATE_POSITION: begin
                place[`SPR_G_TW0_HOST] = at(`SPR_PORT_C, 3'h2, `SPR_SIG_PAIR);
                place[`SPR_G_TW0_CLIENT] = at(`SPR_PORT_C, 3'h6, `SPR_SIG_PAIR);
            end
            default: ;
        endcase
        place[`SPR_G_TW1_HOST] = '0;
        place[`SPR_G_TW1_CLIENT] = '0;
        case (two_wire_pin_route_ff[`SPR_F_UNIT1 +: 2])
            `SPR_CODE_DEFAULT: begin
                place[`SPR_G_TW1_HOST] = at(`SPR_PORT_F, 3'h2, `SPR_SIG_PAIR);
                place[`SPR_G_TW1_CLIENT] = at(`SPR_PORT_B, 3'h2, `SPR_SIG_PAIR);
            end
            `SPR_CODE_FIRST_ALTERNATE_POSITION: begin
                place[`SPR_G_TW1_HOST] = at(`SPR_PORT_F, 3'h2, `SPR_SIG_PAIR);
                place[`SPR_G_TW1_CLIENT] = at(`SPR_PORT_B, 3'h6, `SPR_SIG_PAIR);
            end
            `SPR_CODE_SECOND_ALTERNATE_POSITION: begin
                place[`SPR_G_TW1_HOST] = at(`SPR_PORT_B, 3'h2, `SPR_SIG_PAIR);
                place[`SPR_G_TW1_CLIENT] = at(`SPR_PORT_B, 3'h6, `SPR_SIG_PAIR);
            end
            default: ;
        endcase
    end

    // ----------------------------------------------------------------
    // pad and unit multiplexers
    // ----------------------------------------------------------------
    spr_sync2 #(.WIDTH(`SPR_PORTS * 8)) u_pad_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    // shared pins: enables and driven-high levels are ORed
    always_comb begin
        nxt_pad_drive = '0;
        nxt_unit_in = '0;
        for (int g = 0; g < `SPR_GROUPS; g++) begin
            for (int k = 0; k < 4; k++) begin
                if (place[g].en && place[g].mask[k]) begin
                    nxt_pad_drive[place[g].port].oe[place[g].base + 3'(k)] |=
                        unit_drive[g].oe[k];
                    nxt_pad_drive[place[g].port].out[place[g].base + 3'(k)] |=
                        unit_drive[g].out[k] & unit_drive[g].oe[k];
                    nxt_unit_in[g][k] = pad_sync[place[g].port][place[g].base + 3'(k)];
                end
            end
        end
    end

    // one register stage: a new route switches all pins on one edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pad_drive <= '0;
            unit_in <= '0;
        end else begin
            pad_drive <= nxt_pad_drive;
            unit_in <= nxt_unit_in;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_write_serial_a;
        wr_lane0 && wr_idx == `SPR_IDX_SERIAL_A;
    endsequence

    sequence s_route_lands;
        serial_pin_route_a_ff == $past(w_data_ff[7:0]) ##1
            pad_drive == $past(nxt_pad_drive) &&
            $past(place[0].en) == ($past(serial_pin_route_a_ff[1:0]) <= `SPR_CODE_FIRST_ALTERNATE_POSITION);
    endsequence

    property p_serial3_alt;
        serial_pin_route_a_ff[7:6] == `SPR_CODE_FIRST_ALTERNATE_POSITION |->
            place[3].en && place[3].port == `SPR_PORT_B && place[3].base == 3'h4;
    endproperty
    a_serial3_alt: assert property (p_serial3_alt) else $error("serial 3 alt misplaced");

    property p_serial2_pair;
        serial_pin_route_a_ff[5:4] == `SPR_CODE_FIRST_ALTERNATE_POSITION |->
            place[2].en && place[2].port == `SPR_PORT_F && place[2].base == 3'h4 &&
            place[2].mask == `SPR_SIG_PAIR;
    endproperty
    a_serial2_pair: assert property (p_serial2_pair) else $error("serial 2 alt not pair");

    property p_serial1_default;
        serial_pin_route_a_ff[3:2] == `SPR_CODE_DEFAULT |->
            place[1].en && place[1].port == `SPR_PORT_C && place[1].base == 3'h0;
    endproperty
    a_serial1_default: assert property (p_serial1_default) else $error("serial 1 misplaced");

    property p_none_silent;
        spi_pin_route_ff[1:0] == `SPR_CODE_NONE |=> unit_in[`SPR_G_SPI0] == 4'h0;
    endproperty
    a_none_silent: assert property (p_none_silent) else $error("disconnected unit sees pins");

    property p_serial5_alt;
        serial_pin_route_b_ff[3:2] == `SPR_CODE_FIRST_ALTERNATE_POSITION |->
            place[5].port == `SPR_PORT_G && place[5].base == 3'h4;
    endproperty
    a_serial5_alt: assert property (p_serial5_alt) else $error("serial 5 misplaced");

    property p_spi1_second_alternate_position;
        spi_pin_route_ff[3:2] == `SPR_CODE_SECOND_ALTERNATE_POSITION |->
            place[`SPR_G_SPI1].port == `SPR_PORT_B && place[`SPR_G_SPI1].base == 3'h4;
    endproperty
    a_spi1_second_alternate_position: assert property (p_spi1_second_alternate_position) else $error("spi 1 second_alternate_position misplaced");

    property p_two_wire_reserved;
        two_wire_pin_route_ff[3:2] == `SPR_CODE_NONE |->
            !place[`SPR_G_TW1_HOST].en && !place[`SPR_G_TW1_CLIENT].en;
    endproperty
    a_two_wire_reserved: assert property (p_two_wire_reserved) else $error("reserved code routed");

    property p_reset_clear;
        $fell(reset) |->
            serial_pin_route_a_ff == `SPR_ROUTE_RST &&
            serial_pin_route_b_ff == `SPR_ROUTE_RST &&
            spi_pin_route_ff == `SPR_ROUTE_RST &&
            two_wire_pin_route_ff == `SPR_ROUTE_RST &&
            pad_drive == '0;
    endproperty
    a_reset_clear: assert property (@(posedge ref_clk) p_reset_clear) else $error("route not cleared");

    property p_write_lands;
        s_write_serial_a |=> s_route_lands;
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("route write late at pads");

    property p_only_written;
        $changed(serial_pin_route_a_ff) |-> $past(wr_lane0 && wr_idx == `SPR_IDX_SERIAL_A);
    endproperty
    a_only_written: assert property (p_only_written) else $error("route changed unwritten");

endmodule : spr_pin_router

// >>> spr_far_side.sv
// far-side model: peripheral cores driving one pin group, pads with an outside driver
// assumes pad_drive comes from the pin router; all levels, no clock needed
`timescale 1ns/10ps

module spr_far_side #(
    parameter logic [3:0] PAT = 4'h5
) (
    input wire logic [3:0] active_grp,
    input wire logic [5:0][7:0] ext_level,
    input wire spr_pkg::spr_pad_drive_t [5:0] pad_drive,
    output spr_pkg::spr_sig_drive_t [11:0] unit_drive,
    output logic [5:0][7:0] pad_in
);
    always_comb begin
        unit_drive = '0;
        unit_drive[active_grp] = {PAT, 4'hF};
    end
    // a driven pad reads its own level, else the outside device's
    for (genvar p = 0; p < 6; p++) begin : g_pad
        assign pad_in[p] = (pad_drive[p].out & pad_drive[p].oe) | (ext_level[p] & ~pad_drive[p].oe);
    end
endmodule : spr_far_side

// >>> testbench.sv
// testbench: register access and placement of every pin group under every code
// assumes spr_far_side stands in for the cores and pads
`timescale 1ns/10ps

module testbench;
    localparam logic [3:0] PAT = 4'h5;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    spr_pkg::spr_axil_req_t req = '0;
    spr_pkg::spr_axil_rsp_t rsp;
    spr_pkg::spr_sig_drive_t [11:0] unit_drive;
    logic [11:0][3:0] unit_in;
    logic [5:0][7:0] pad_in;
    spr_pkg::spr_pad_drive_t [5:0] pad_drive;
    logic [3:0] active_grp = 4'h0;
    logic [5:0][7:0] ext_level = '1;
    int bad_count = 0;
    int tests_run = 0;
    logic [1:0] resp;
    logic [31:0] rd;
    // {port, base} per group for codes 0..2; 6'h3F means not connected
    logic [5:0] place_tbl [12][3] = '{
        '{6'h00, 6'h04, 6'h3F}, '{6'h10, 6'h14, 6'h3F}, '{6'h20, 6'h24, 6'h3F},
        '{6'h08, 6'h0C, 6'h3F}, '{6'h18, 6'h1C, 6'h3F}, '{6'h28, 6'h2C, 6'h3F},
        '{6'h04, 6'h18, 6'h2C}, '{6'h10, 6'h14, 6'h0C}, '{6'h02, 6'h02, 6'h12},
        '{6'h12, 6'h16, 6'h16}, '{6'h22, 6'h22, 6'h0A}, '{6'h0A, 6'h0E, 6'h0E}};

    always #2.5 ref_clk = ~ref_clk;

    spr_pin_router DUT (.ref_clk(ref_clk), .reset(reset), .axil_req(req), .axil_rsp(rsp),
        .unit_drive(unit_drive), .unit_in(unit_in), .pad_in(pad_in), .pad_drive(pad_drive));

    spr_far_side #(.PAT(PAT)) far (.active_grp(active_grp), .ext_level(ext_level),
        .pad_drive(pad_drive), .unit_drive(unit_drive), .pad_in(pad_in));

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic close_out();
        if (bad_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic cmp(input string what, input logic [95:0] exp, input logic [95:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // ----------------------------------------------------------------
    // bus master
    // ----------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!(req.bready && rsp.bvalid) && n < 40);
        resp = rsp.bresp;
        req.bready <= 1'b0;
        if (n >= 40) begin
            bad_count++;
            close_out();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!(req.rready && rsp.rvalid) && n < 40);
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        if (n >= 40) begin
            bad_count++;
            close_out();
        end
    endtask : axi_rd

    // ----------------------------------------------------------------
    // expected placement
    // ----------------------------------------------------------------
    function automatic logic [3:0] exp_mask(int g, int c);
        if (c == 3 || place_tbl[g][c] == 6'h3F)
            return 4'h0;
        return (g >= 8 || (g == 2 && c == 1)) ? 4'h3 : 4'hF;
    endfunction : exp_mask

    function automatic logic [95:0] exp_pads(int g, int c);
        spr_pkg::spr_pad_drive_t [5:0] p;
        logic [5:0] e;
        p = '0;
        e = (c < 3) ? place_tbl[g][c] : 6'h3F;
        if (exp_mask(g, c) != 4'h0) begin
            p[e[5:3]].out = 8'(PAT & exp_mask(g, c)) << e[2:0];
            p[e[5:3]].oe = 8'(exp_mask(g, c)) << e[2:0];
        end
        return p;
    endfunction : exp_pads

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] a;
        logic [31:0] v;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 2; i < 6; i++) begin
            axi_rd(8'(4 * i));
            cmp("route reset value", 96'h0, rd);
        end
        axi_rd(8'h18);
        cmp("unmapped read resp", 96'h2, resp);
        cmp("unmapped read data", 96'h0, rd);
        axi_wr(8'h09, 32'h0000_0003, 4'hF);
        cmp("misaligned write resp", 96'h2, resp);
        axi_wr(8'h0C, 32'h0000_00FF, 4'hF);
        axi_rd(8'h0C);
        cmp("route b reserved bits", 96'h0F, rd);
        axi_wr(8'h10, 32'h0000_0003, 4'h0);
        cmp("no strobe write resp", 96'h0, resp);
        axi_rd(8'h10);
        cmp("no strobe write", 96'h0, rd);
        for (int g = 0; g < 12; g++) begin
            active_grp <= 4'(g);
            a = (g < 4) ? 8'h08 : (g < 6) ? 8'h0C : (g < 8) ? 8'h10 : 8'h14;
            for (int c = 0; c < 4; c++) begin
                v = (g < 4) ? 32'(c) << (2 * g) : (g < 8) ? 32'(c) << (2 * (g % 2)) :
                    32'(c) << (2 * ((g - 8) / 2));
                axi_wr(a, v, 4'hF);
                axi_rd(a);
                cmp("route readback", 96'(v), rd);
                repeat (6) @(posedge ref_clk);
                cmp("pad drive", exp_pads(g, c), pad_drive);
                cmp("unit input", 96'(PAT & exp_mask(g, c)), unit_in[g]);
            end
        end
        close_out();
    end
endmodule : testbench
